// ==== rtl/quadrature_counter_pulse_meter.sv ====
// Two-channel quadrature counter and four-input pulse meter behind APB
// Function
// - Two counters; inputs 1,2 drive channel one, inputs 3,4 channel two.
// - Simple mode counts up when A leads B, down when A lags.
// - B held off makes A pulses count up, allowing single-phase use.
// - Default resolution changes count by one per full quadrature cycle.
// - Enhanced decoding uses both phases so edge jitter gives no extra counts.
// - Setting four bit 0 and bit 1 pick simple or enhanced per channel.
// - Setting twenty-four upper byte picks channel one or two only.
// - Setting twenty-four lower byte: 0 simple, 1 x1, 2 x2, 3 x4.
// - x2 counts every two edges, x4 counts every edge of either phase.
// - Setting twenty-four replaces mode earlier set by setting four.
// - Count reaching programmed target raises event; software reloads target.
// - Defining a counter also enables pulse measurement on its pins.
// - Interrupt pins lose counter and measurement functions.
// - Pins without special function read as plain on/off inputs.
// - Each of four inputs measures on width, period and frequency.
// - Width and period default to microseconds, frequency to hertz.
// - Setting twenty value one gives width and period in tenth microseconds.
// - Measurement enable on a pin with active counter disables that counter.
// - Measurement enable alone does not enable the counter.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module quadrature_counter_pulse_meter
    import quad_pkg::*;
#(
    parameter int GATE_CYCLES = GATE_CYCLES_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] pins,
    output logic [3:0] digital_in,
    output logic [1:0] compare_event
);
    ////////////////////////////////////////////////////////////////
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_q;
    logic [3:0] rise;
    logic [3:0] fall;
    logic wr;
    logic [31:0] rdata;
    logic rerr;
    logic [1:0] cnt_en;
    logic [3:0] pm_en;
    logic [3:0] intr_pin;
    mode_type mode [2];
    logic tenth_units;
    logic [31:0] target [2];
    logic [31:0] count [2];
    logic [1:0] hit;
    logic [1:0] evt;
    logic [1:0] load;
    logic [5:0] us_div;
    logic [5:0] tenth_acc;
    logic [5:0] next_tenth_acc;
    logic [31:0] us_tb;
    logic [31:0] tenth_tb;
    logic [31:0] tb;
    logic [31:0] gate_cnt;
    logic gate_end;
    logic [3:0] have_rise;
    logic [31:0] rise_stamp [4];
    logic [31:0] width [4];
    logic [31:0] period [4];
    logic [31:0] edge_cnt [4];
    logic [31:0] freq [4];

    ////////////////////////////////////////////////////////////////
    // Input synchroniser and edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
            pin_q <= 4'h0;
            digital_in <= 4'h0;
        end else begin
            pin_s1 <= pins;
            pin_s2 <= pin_s1;
            pin_q <= pin_s2;
            digital_in <= pin_s2;
        end
    end

    assign rise = pin_s2 & ~pin_q;
    assign fall = ~pin_s2 & pin_q;

    ////////////////////////////////////////////////////////////////
    // APB slave, one wait state on every access
    assign wr = psel && penable && pready && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready) begin
                prdata <= pwrite ? 32'h0000_0000 : rdata;
                pslverr <= rerr;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    always_comb begin
        rdata = 32'h0000_0000;
        rerr = 1'b0;
        case (paddr & ARRAY_MASK)
            WIDTH_BASE: rdata = width[paddr[3:2]];
            PERIOD_BASE: rdata = period[paddr[3:2]];
            FREQ_BASE: rdata = freq[paddr[3:2]];
            default: begin
                case (paddr)
                    SYS4_OFS: rdata = {30'h0, mode[1] != MODE_SIMPLE, mode[0] != MODE_SIMPLE};
                    SYS24_OFS: rdata = {28'h0, 2'(mode[1]), 2'(mode[0])};
                    SYS20_OFS: rdata = {31'h0, tenth_units};
                    CMD_OFS: rdata = 32'h0000_0000;
                    INTR_OFS: rdata = {28'h0, intr_pin};
                    STATUS_OFS: begin
                        rdata[ST_CNT_LSB +: 2] = cnt_en;
                        rdata[ST_PM_LSB +: 4] = pm_en;
                        rdata[ST_PIN_LSB +: 4] = pin_s2;
                        rdata[ST_INTR_LSB +: 4] = intr_pin;
                        rdata[ST_EVT_LSB +: 2] = evt;
                    end
                    COUNT0_OFS: rdata = count[0];
                    COUNT1_OFS: rdata = count[1];
                    TARGET0_OFS: rdata = target[0];
                    TARGET1_OFS: rdata = target[1];
                    default: rerr = 1'b1;
                endcase
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode[0] <= MODE_SIMPLE;
            mode[1] <= MODE_SIMPLE;
        end else if (wr && paddr == SYS4_OFS) begin
            mode[0] <= pwdata[0] ? MODE_X1 : MODE_SIMPLE;
            mode[1] <= pwdata[1] ? MODE_X1 : MODE_SIMPLE;
        end else if (wr && paddr == SYS24_OFS) begin
            // Last write wins, so this replaces the setting-four mode
            if (pwdata[SYS24_CHAN_LSB +: 8] == CHAN1_CODE) begin
                mode[0] <= mode_type'(pwdata[1:0]);
            end
            if (pwdata[SYS24_CHAN_LSB +: 8] == CHAN2_CODE) begin
                mode[1] <= mode_type'(pwdata[1:0]);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tenth_units <= 1'b0;
        end else if (wr && paddr == SYS20_OFS) begin
            tenth_units <= (pwdata == 32'h0000_0001);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            intr_pin <= 4'h0;
        end else if (wr && paddr == INTR_OFS) begin
            intr_pin <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target[0] <= TARGET_RESET;
            target[1] <= TARGET_RESET;
        end else if (wr && paddr == TARGET0_OFS) begin
            target[0] <= pwdata;
        end else if (wr && paddr == TARGET1_OFS) begin
            target[1] <= pwdata;
        end
    end

    assign load[0] = wr && paddr == COUNT0_OFS;
    assign load[1] = wr && paddr == COUNT1_OFS;

    ////////////////////////////////////////////////////////////////
    // Function ownership of the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_en <= 2'b00;
        end else if (wr && paddr == CMD_OFS) begin
            for (int c = 0; c < 2; c++) begin
                if (pwdata[CMD_DEFINE_LSB + c] && intr_pin[2 * c +: 2] == 2'b00) begin
                    cnt_en[c] <= 1'b1;
                end
                if (pwdata[CMD_DISABLE_LSB + c]) begin
                    cnt_en[c] <= 1'b0;
                end
                if (pwdata[CMD_PM_LSB + 2 * c +: 2] != 2'b00) begin
                    cnt_en[c] <= 1'b0;
                end
            end
        end else if (wr && paddr == INTR_OFS) begin
            for (int c = 0; c < 2; c++) begin
                if (pwdata[2 * c +: 2] != 2'b00) begin
                    cnt_en[c] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pm_en <= 4'h0;
        end else if (wr && paddr == CMD_OFS) begin
            for (int p = 0; p < 4; p++) begin
                // Measurement enable never touches the counter enable here
                if ((pwdata[CMD_PM_LSB + p] || pwdata[CMD_DEFINE_LSB + p / 2]) && !intr_pin[p]) begin
                    pm_en[p] <= 1'b1;
                end
            end
        end else if (wr && paddr == INTR_OFS) begin
            pm_en <= pm_en & ~pwdata[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Counter channels
    for (genvar c = 0; c < 2; c++) begin : g_chan
        quad_channel u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .phase_a(pin_s2[2 * c]),
            .phase_b(pin_s2[2 * c + 1]),
            .enable(cnt_en[c]),
            .mode(mode[c]),
            .load(load[c]),
            .load_value(pwdata),
            .target(target[c]),
            .count(count[c]),
            .hit(hit[c])
        );
    end

    // Sticky compare flags; a new hit wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt <= 2'b00;
            compare_event <= 2'b00;
        end else begin
            compare_event <= hit & cnt_en;
            if (wr && paddr == STATUS_OFS) begin
                evt <= (evt & ~pwdata[ST_EVT_LSB +: 2]) | hit;
            end else begin
                evt <= evt | hit;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Free-running timebases in microseconds and tenths
    assign next_tenth_acc = 6'(tenth_acc + TENTH_STEP);
    assign tb = tenth_units ? tenth_tb : us_tb;
    assign gate_end = (gate_cnt == 32'(GATE_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            us_div <= 6'h00;
            us_tb <= 32'h0000_0000;
        end else if (us_div == US_DIV_LAST) begin
            us_div <= 6'h00;
            us_tb <= 32'(us_tb + 32'h0000_0001);
        end else begin
            us_div <= 6'(us_div + 6'h01);
        end
    end

    // Fractional step keeps the tenth count exact at a non-integer ratio
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tenth_acc <= 6'h00;
            tenth_tb <= 32'h0000_0000;
        end else if (next_tenth_acc >= TENTH_WRAP) begin
            tenth_acc <= 6'(next_tenth_acc - TENTH_WRAP);
            tenth_tb <= 32'(tenth_tb + 32'h0000_0001);
        end else begin
            tenth_acc <= next_tenth_acc;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_cnt <= 32'h0000_0000;
        end else if (gate_end) begin
            gate_cnt <= 32'h0000_0000;
        end else begin
            gate_cnt <= 32'(gate_cnt + 32'h0000_0001);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Pulse meters, one per input
    for (genvar p = 0; p < 4; p++) begin : g_meter
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                have_rise[p] <= 1'b0;
                rise_stamp[p] <= 32'h0000_0000;
                width[p] <= 32'h0000_0000;
                period[p] <= 32'h0000_0000;
            end else if (!pm_en[p]) begin
                have_rise[p] <= 1'b0;
            end else if (rise[p]) begin
                have_rise[p] <= 1'b1;
                rise_stamp[p] <= tb;
                if (have_rise[p]) begin
                    period[p] <= 32'(tb - rise_stamp[p]);
                end
            end else if (fall[p] && have_rise[p]) begin
                width[p] <= 32'(tb - rise_stamp[p]);
            end
        end

        // Rising edges per gate window give hertz when the gate is one second
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                edge_cnt[p] <= 32'h0000_0000;
                freq[p] <= 32'h0000_0000;
            end else if (gate_end) begin
                freq[p] <= pm_en[p] ? edge_cnt[p] : 32'h0000_0000;
                edge_cnt[p] <= {31'h0, pm_en[p] && rise[p]};
            end else if (pm_en[p] && rise[p]) begin
                edge_cnt[p] <= 32'(edge_cnt[p] + 32'h0000_0001);
            end
        end
    end
endmodule // quadrature_counter_pulse_meter
`default_nettype wire

// ==== shared/quad_pkg.sv ====
// Constants, offsets and types for the quadrature counter and pulse meter
package quad_pkg;
    // Core clock and timing
    localparam int CLK_HZ = 25_000_000;
    localparam int CYCLES_PER_US = CLK_HZ / 1_000_000;
    localparam int TENTHS_PER_US = 10;
    localparam int GATE_TIME_MS = 1000;
    localparam int GATE_CYCLES_DEFAULT = CLK_HZ / 1000 * GATE_TIME_MS;
    localparam logic [5:0] US_DIV_LAST = 6'(CYCLES_PER_US - 1);
    localparam logic [5:0] TENTH_STEP = 6'(TENTHS_PER_US);
    localparam logic [5:0] TENTH_WRAP = 6'(CYCLES_PER_US);

    // Register byte offsets
    localparam logic [7:0] SYS4_OFS = 8'h00;
    localparam logic [7:0] SYS24_OFS = 8'h04;
    localparam logic [7:0] SYS20_OFS = 8'h08;
    localparam logic [7:0] CMD_OFS = 8'h0c;
    localparam logic [7:0] INTR_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;
    localparam logic [7:0] COUNT0_OFS = 8'h18;
    localparam logic [7:0] COUNT1_OFS = 8'h1c;
    localparam logic [7:0] TARGET0_OFS = 8'h20;
    localparam logic [7:0] TARGET1_OFS = 8'h24;
    localparam logic [7:0] WIDTH_BASE = 8'h30;
    localparam logic [7:0] PERIOD_BASE = 8'h40;
    localparam logic [7:0] FREQ_BASE = 8'h50;
    localparam logic [7:0] ARRAY_MASK = 8'hf3;

    // Field positions
    localparam int CMD_DEFINE_LSB = 0;
    localparam int CMD_DISABLE_LSB = 2;
    localparam int CMD_PM_LSB = 4;
    localparam int SYS24_CHAN_LSB = 8;
    localparam int ST_CNT_LSB = 0;
    localparam int ST_PM_LSB = 2;
    localparam int ST_PIN_LSB = 6;
    localparam int ST_INTR_LSB = 10;
    localparam int ST_EVT_LSB = 14;
    localparam logic [7:0] CHAN1_CODE = 8'h01;
    localparam logic [7:0] CHAN2_CODE = 8'h02;

    // Reset values
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [31:0] TARGET_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {MODE_SIMPLE, MODE_X1, MODE_X2, MODE_X4} mode_type;
endpackage

// ==== rtl/quad_channel.sv ====
// One quadrature counter channel: decoder, signed counter and compare
`timescale 1ns/100ps
`default_nettype none
module quad_channel
    import quad_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic phase_a,
    input wire logic phase_b,
    input wire logic enable,
    input wire mode_type mode,
    input wire logic load,
    input wire logic [31:0] load_value,
    input wire logic [31:0] target,
    output logic [31:0] count,
    output logic hit
);
    logic a_q;
    logic b_q;
    logic [1:0] ph_prev;
    logic [1:0] ph_cur;
    logic fwd;
    logic back;
    logic inc;
    logic dec;
    logic [31:0] next_count;

    // Gray position 0..3 along the A-leads direction
    assign ph_cur = {phase_b, phase_a ^ phase_b};
    assign ph_prev = {b_q, a_q ^ b_q};
    assign fwd = (ph_cur == 2'(ph_prev + 2'd1));
    assign back = (ph_prev == 2'(ph_cur + 2'd1));

    always_comb begin
        inc = 1'b0;
        dec = 1'b0;
        case (mode)
            MODE_SIMPLE: begin
                // B low at A rise means A leads; B held off counts up
                if (phase_a && !a_q) begin
                    inc = !phase_b;
                    dec = phase_b;
                end
            end
            MODE_X1: begin
                // Only the 3-0 boundary counts, so jitter nets to zero
                inc = fwd && (ph_cur == 2'd0);
                dec = back && (ph_prev == 2'd0);
            end
            MODE_X2: begin
                inc = fwd && !ph_cur[0];
                dec = back && !ph_prev[0];
            end
            MODE_X4: begin
                inc = fwd;
                dec = back;
            end
            default: begin
                inc = 1'b0;
                dec = 1'b0;
            end
        endcase
    end

    assign next_count = inc ? 32'(count + 32'h0000_0001) : 32'(count - 32'h0000_0001);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
        end else begin
            a_q <= phase_a;
            b_q <= phase_b;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= COUNT_RESET;
        end else if (load) begin
            count <= load_value;
        end else if (enable && (inc || dec)) begin
            count <= next_count;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit <= 1'b0;
        end else begin
            hit <= enable && !load && (inc || dec) && (next_count == target);
        end
    end
endmodule // quad_channel
`default_nettype wire

// ==== verif/quad_encoder.sv ====
// Encoder model: quadrature steps and single-phase pulses at a limited rate
`timescale 1ns/100ps
`default_nettype none
module quad_encoder #(
    parameter int HOLD = 625
) (
    input wire logic pclk,
    output logic [3:0] pins
);
    logic [1:0] pos [2];

    initial begin
        pins = 4'h0;
        pos[0] = 2'h0;
        pos[1] = 2'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Forward order of {A,B} is 00, 10, 11, 01, so A leads B
    task automatic turn(input int ch, input int n, input logic fwd);
        repeat (4 * n) begin
            pos[ch] = fwd ? pos[ch] + 2'h1 : pos[ch] - 2'h1;
            @(posedge pclk);
            pins[2 * ch] <= pos[ch][1] ^ pos[ch][0];
            pins[2 * ch + 1] <= pos[ch][1];
            repeat (HOLD - 1) @(posedge pclk);
        end
    endtask

    // Static levels for plain input use; phase positions are not kept
    task automatic hold(input logic [3:0] v);
        @(posedge pclk);
        pins <= v;
    endtask

    // One pin toggled alone, the partner phase left unchanged
    task automatic pulse(input int pin, input int n);
        repeat (2 * n) begin
            @(posedge pclk);
            pins[pin] <= ~pins[pin];
            repeat (2 * HOLD - 1) @(posedge pclk);
        end
    endtask
endmodule // quad_encoder
`default_nettype wire

// ==== verif/quad_chk.sv ====
// Checker for bus answer timing, input sync and compare events
`timescale 1ns/100ps
`default_nettype none
module quad_chk
    import quad_pkg::*;
#(
    parameter int GATE_CYCLES = GATE_CYCLES_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] pins,
    input wire logic [3:0] digital_in,
    input wire logic [1:0] compare_event
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////////
    a_ready_second: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
        else $error("pready outside access or too long");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_unmapped: assert property (pready && paddr >= 8'h60 |-> pslverr)
        else $error("unmapped access not refused");
    a_no_err_mapped: assert property (pready && paddr <= 8'h24 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    a_rdata_hold: assert property ($changed(prdata) |-> pready)
        else $error("prdata moved between answers");
    a_write_rdata: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
        else $error("read data not cleared on write answer");
    a_sync_delay: assert property (digital_in == $past(pins, 3))
        else $error("digital_in not pins three clocks late");
    a_event_single: assert property (compare_event[0] |=> !compare_event[0])
        else $error("compare event longer than one cycle");
    a_event_cause: assert property (compare_event[0] |-> $past(pins[1:0], 4) != $past(pins[1:0], 5))
        else $error("channel one event without input step");
    a_event_cause2: assert property (compare_event[1] |-> $past(pins[3:2], 4) != $past(pins[3:2], 5))
        else $error("channel two event without input step");
endmodule // quad_chk
bind quadrature_counter_pulse_meter quad_chk #(.GATE_CYCLES(GATE_CYCLES)) chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .digital_in(digital_in), .compare_event(compare_event));
`default_nettype wire

// ==== verif/tb.sv ====
// Bench: register access over APB with an encoder model on the inputs
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb
    import quad_pkg::*;
;
    // Short gate so a frequency window holds four input periods
    localparam int GATE = 10000;
    localparam logic [32:0] FULL = 33'h1_ffff_ffff;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] pins;
    logic [3:0] digital_in;
    logic [1:0] compare_event;
    int num_errors = 0;
    int n_tests = 0;
    int ev0 = 0;
    int ev1 = 0;

    always #20 pclk = ~pclk;

    // Compare pulses stand one cycle, so each is seen at exactly one edge
    always @(posedge pclk) begin
        if (compare_event[0] === 1'b1) begin
            ev0++;
        end
        if (compare_event[1] === 1'b1) begin
            ev1++;
        end
    end

    quadrature_counter_pulse_meter #(.GATE_CYCLES(GATE)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .digital_in(digital_in), .compare_event(compare_event));
    quad_encoder enc (.pclk(pclk), .pins(pins));

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Idle edge first, so psel is never set twice in one time step
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [32:0] res);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        res = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            num_errors++;
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [32:0] r;
        apb(a, 1'b1, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] x, input logic [32:0] m, input string nm);
        logic [32:0] r;
        apb(a, 1'b0, 32'h0, r);
        `CHK(nm, x, r & m)
    endtask

    function automatic logic [32:0] ok(input logic [31:0] d);
        return {1'b0, d};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(COUNT0_OFS, ok(32'h0), FULL, "count reset");
        rd(STATUS_OFS, ok(32'h0), FULL, "status reset");
        rd(SYS20_OFS, ok(32'h0), FULL, "unit reset");
        rd(8'h60, {1'b1, 32'h0}, FULL, "unmapped read");
        wr(TARGET0_OFS, 32'h03);
        wr(CMD_OFS, 32'h01);
        enc.turn(0, 12, 1'b1);
        rd(COUNT0_OFS, ok(32'h0c), FULL, "count forward");
        rd(STATUS_OFS, ok(32'h400d), 33'hc03f, "status defined");
        for (int p = 0; p < 2; p++) begin
            rd(WIDTH_BASE + 8'(4 * p), ok(32'h32), FULL, "width");
            rd(PERIOD_BASE + 8'(4 * p), ok(32'h64), FULL, "period");
            rd(FREQ_BASE + 8'(4 * p), ok(32'h04), FULL, "frequency");
        end
        wr(SYS20_OFS, 32'h01);
        enc.turn(0, 2, 1'b1);
        rd(WIDTH_BASE, ok(32'h1f4), FULL, "width tenths");
        rd(PERIOD_BASE, ok(32'h3e8), FULL, "period tenths");
        enc.turn(0, 2, 1'b0);
        rd(COUNT0_OFS, ok(32'h0c), FULL, "count reverse");
        enc.pulse(0, 2);
        rd(COUNT0_OFS, ok(32'h0e), FULL, "count one phase");
        wr(TARGET1_OFS, 32'h01);
        wr(CMD_OFS, 32'h02);
        enc.turn(1, 1, 1'b1);
        rd(COUNT1_OFS, ok(32'h01), FULL, "count channel two");
        wr(SYS4_OFS, 32'h03);
        rd(SYS24_OFS, ok(32'h05), 33'h0f, "modes by sys4");
        wr(SYS24_OFS, 32'h0100);
        rd(SYS24_OFS, ok(32'h04), 33'h0f, "modes by sys24");
        rd(SYS4_OFS, ok(32'h02), 33'h03, "sys4 view");
        wr(SYS24_OFS, 32'h0302);
        rd(SYS24_OFS, ok(32'h04), 33'h0f, "bad channel code");
        for (int m = 1; m < 4; m++) begin
            wr(SYS24_OFS, 32'h0100 | 32'(m));
            wr(COUNT0_OFS, 32'h0);
            enc.turn(0, 1, 1'b1);
            rd(COUNT0_OFS, ok(32'h1 << (m - 1)), FULL, "scaled count");
        end
        // A toggled with B off: simple mode would add three here
        enc.pulse(0, 3);
        rd(COUNT0_OFS, ok(32'h04), FULL, "jitter rejected");
        wr(CMD_OFS, 32'h04);
        enc.turn(0, 1, 1'b1);
        rd(COUNT0_OFS, ok(32'h04), FULL, "count held");
        wr(CMD_OFS, 32'h01);
        wr(CMD_OFS, 32'h10);
        rd(STATUS_OFS, ok(32'h02), 33'h03, "meter stops counter");
        wr(CMD_OFS, 32'h08);
        wr(CMD_OFS, 32'h40);
        rd(STATUS_OFS, ok(32'h10), 33'h13, "meter alone");
        wr(INTR_OFS, 32'h01);
        wr(CMD_OFS, 32'h01);
        rd(STATUS_OFS, ok(32'h438), 33'h3c3f, "interrupt pin");
        enc.hold(4'ha);
        repeat (4) @(posedge pclk);
        `CHK("plain inputs", 4'ha, digital_in)
        rd(STATUS_OFS, ok(32'h280), 33'h3c0, "status pins");
        `CHK("compare events one", 2, ev0)
        `CHK("compare events two", 1, ev1)
        report_and_stop();
    end
endmodule // tb
`undef CHK
`default_nettype wire
